// ---- logic/scb_pkg.sv ----
// Constants for the system control safe access register bank
package scb_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] SCB_ADDR_UNLOCK_SIG = 32'h4000_1040;
   localparam logic [31:0] SCB_ADDR_PART_ID = 32'h4000_1041;
   localparam logic [31:0] SCB_ADDR_UNLOCK_ID = 32'h4000_1042;
   localparam logic [31:0] SCB_ADDR_WDOG_CNT = 32'h4000_1043;
   localparam logic [31:0] SCB_ADDR_RESET_CAUSE = 32'h4000_1044;
   localparam logic [31:0] SCB_ADDR_CFG_INFO = 32'h4000_1045;
   localparam logic [31:0] SCB_ADDR_WDOG_CTRL = 32'h4000_1046;
   localparam logic [31:0] SCB_ADDR_RESET_KEEP = 32'h4000_1047;
   localparam logic [31:0] SCB_ADDR_FLASH_WORD = 32'h4000_1800;
   localparam logic [31:0] SCB_ADDR_FLASH_CTRL_WORD = 32'h4000_1804;
   localparam logic [31:0] SCB_ADDR_FLASH_ACC_CTRL = 32'h4000_1806;
   localparam logic [31:0] SCB_ADDR_FLASH_ACC_CFG = 32'h4000_1807;
   localparam logic [31:0] SCB_ADDR_IRQ_STATUS = 32'h4000_1048;
   localparam logic [31:0] SCB_ADDR_IRQ_MASK = 32'h4000_1049;
   // ----------------------------------------------------------------
   // Unlock sequence and fixed values
   // ----------------------------------------------------------------
   localparam logic [7:0] SCB_KEY_FIRST = 8'h57;
   localparam logic [7:0] SCB_KEY_SECOND = 8'hA8;
   localparam logic [7:0] SCB_UNLOCK_ID_VAL = 8'h0C;
   localparam logic [7:0] SCB_PART_ID_DEFAULT = 8'h5A;  // Arbitrary value
   localparam logic [1:0] SCB_STATE_CODE_SAFE = 2'h3;
   localparam logic [1:0] SCB_STATE_CODE_LOCKED = 2'h0;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SCB_ELAPSED_LSB = 4;
   localparam int SCB_WRITABLE_BIT = 3;
   localparam int SCB_WDOG_FLAG_BIT = 4;
   localparam int SCB_IRQ_WINDOW_BIT = 0;
   localparam int SCB_IRQ_WDOG_BIT = 1;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SCB_RST_ZERO = 8'h00;
   localparam logic [7:0] SCB_RST_RESET_CAUSE = 8'h01;
   localparam logic [7:0] SCB_RST_FLASH_ACC_CTRL = 8'h40;
   localparam logic [7:0] SCB_RST_FLASH_ACC_CFG = 8'h07;
   localparam logic [31:0] SCB_RST_FLASH_WORD = 32'h0000_0000;
   localparam logic [7:0] SCB_CFG_INFO_VAL = 8'hC8;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SCB_WINDOW_CYCLES = 16;
   localparam logic [4:0] SCB_WINDOW_LAST = 5'(SCB_WINDOW_CYCLES - 1);
   localparam int SCB_WDOG_TICK_CYCLES = 131072;
   // ----------------------------------------------------------------
   // Unlock sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCB_LOCKED = 2'b00,
      SCB_ARMED = 2'b01,
      SCB_OPEN = 2'b11
   } scb_unlock_t;
endpackage : scb_pkg

// ---- logic/scb_bank.sv ----
// System control register bank with timed unlock window and watchdog counter
// Functional notes
// - Write 0x57 then 0xA8 opens window
// - Protected registers written only when window open
// - Window closes itself after 16 cycles
// - Other unlock-register write closes open window
// - Bits 6:4 show elapsed window count
// - Bit 3 shows writable status
// - Bits 1:0 read 11 in safe mode
// - Unlock register reads zero after reset
// - Part identifier constant, writes ignored
// - Unlock identifier always reads 0x0C
// - Watchdog counter presettable, resets to zero
// - Watchdog counter wraps 0xFF to 0x00
// - Watchdog advances every 131072 clocks
// - Reset cause, ROM config share 0x40001044
// - Flash access control, config are control word bytes 2, 3
// - Protected registers always readable
// - Watchdog wrap sets overflow flag
`timescale 1ns/1ps
module scb_bank
   import scb_pkg::*;
#(
   parameter logic [7:0] PART_ID = SCB_PART_ID_DEFAULT,  // Arbitrary value
   parameter int WDOG_TICK = SCB_WDOG_TICK_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Register port
   input wire logic [31:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Status outputs
   output logic unlock_writable_out,
   output logic irq_out
);
   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic wr_sig;
   logic wr_wdog_cnt;
   logic wr_cause;
   logic wr_wdog_ctrl;
   logic wr_keep;
   logic wr_flash_word;
   logic wr_flash_ctrl;
   logic wr_acc_ctrl;
   logic wr_acc_cfg;
   logic wr_irq_mask;
   logic rd_irq_status;
   logic unlock_open;

   // Write strobes per register
   assign wr_sig = reg_wr_in && (reg_addr_in == SCB_ADDR_UNLOCK_SIG);
   assign wr_wdog_cnt = reg_wr_in && (reg_addr_in == SCB_ADDR_WDOG_CNT);
   assign wr_cause = reg_wr_in && (reg_addr_in == SCB_ADDR_RESET_CAUSE);
   assign wr_wdog_ctrl = reg_wr_in && (reg_addr_in == SCB_ADDR_WDOG_CTRL);
   assign wr_keep = reg_wr_in && (reg_addr_in == SCB_ADDR_RESET_KEEP);
   assign wr_flash_word = reg_wr_in && (reg_addr_in == SCB_ADDR_FLASH_WORD);
   assign wr_flash_ctrl = reg_wr_in && (reg_addr_in == SCB_ADDR_FLASH_CTRL_WORD);
   assign wr_acc_ctrl = reg_wr_in && (reg_addr_in == SCB_ADDR_FLASH_ACC_CTRL);
   assign wr_acc_cfg = reg_wr_in && (reg_addr_in == SCB_ADDR_FLASH_ACC_CFG);
   assign wr_irq_mask = reg_wr_in && (reg_addr_in == SCB_ADDR_IRQ_MASK);
   assign rd_irq_status = reg_rd_in && (reg_addr_in == SCB_ADDR_IRQ_STATUS);

   // ----------------------------------------------------------------
   // Unlock sequencer
   // ----------------------------------------------------------------
   scb_unlock_t unlock_state_ff;
   scb_unlock_t nxt_unlock_state;
   logic [4:0] window_cnt_ff;
   logic window_expire;
   logic window_opened;

   assign window_expire = (unlock_state_ff == SCB_OPEN) && (window_cnt_ff == SCB_WINDOW_LAST);
   assign window_opened = (unlock_state_ff == SCB_ARMED) && wr_sig && (reg_wdata_in[7:0] == SCB_KEY_SECOND);

   // Next state of the key sequence
   always_comb begin
      nxt_unlock_state = unlock_state_ff;
      unique case (unlock_state_ff)
         SCB_LOCKED: begin
            if (wr_sig && (reg_wdata_in[7:0] == SCB_KEY_FIRST)) begin
               nxt_unlock_state = SCB_ARMED;
            end
         end
         SCB_ARMED: begin
            if (window_opened) begin
               nxt_unlock_state = SCB_OPEN;
            end else if (reg_wr_in) begin
               nxt_unlock_state = SCB_LOCKED;
            end
         end
         SCB_OPEN: begin
            if (wr_sig || window_expire) begin
               nxt_unlock_state = SCB_LOCKED;
            end
         end
         default: begin
            nxt_unlock_state = SCB_LOCKED;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         unlock_state_ff <= SCB_LOCKED;
      end else begin
         unlock_state_ff <= nxt_unlock_state;
      end
   end

   // Elapsed cycles of the open window
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         window_cnt_ff <= 5'h00;
      end else if (unlock_state_ff == SCB_OPEN && nxt_unlock_state == SCB_OPEN) begin
         window_cnt_ff <= window_cnt_ff + 5'h01;
      end else begin
         window_cnt_ff <= 5'h00;
      end
   end

   assign unlock_open = (unlock_state_ff == SCB_OPEN);
   assign unlock_writable_out = unlock_open;

   // ----------------------------------------------------------------
   // Protected and plain storage registers
   // ----------------------------------------------------------------
   logic [7:0] cause_cfg_ff;
   logic [7:0] wdog_ctrl_ff;
   logic [7:0] keep_ff;
   logic [31:0] flash_word_ff;
   logic [31:0] flash_ctrl_ff;
   logic [1:0] irq_mask_ff;

   // Reset cause and ROM config; upper bits need the window
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cause_cfg_ff <= SCB_RST_RESET_CAUSE;
      end else if (wr_cause && unlock_open) begin
         cause_cfg_ff[7:4] <= reg_wdata_in[7:4];
      end
   end

   // Watchdog control enables need the window
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wdog_ctrl_ff <= SCB_RST_ZERO;
      end else if (wr_wdog_ctrl && unlock_open) begin
         wdog_ctrl_ff[2:1] <= reg_wdata_in[2:1];
      end
   end

   // Scratch keep register, free write
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         keep_ff <= SCB_RST_ZERO;
      end else if (wr_keep) begin
         keep_ff <= reg_wdata_in[7:0];
      end
   end

   // Flash word data holding register
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flash_word_ff <= SCB_RST_FLASH_WORD;
      end else if (wr_flash_word) begin
         flash_word_ff <= reg_wdata_in;
      end
   end

   // Flash control word; byte lanes 2 and 3 also at their own addresses
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flash_ctrl_ff <= {SCB_RST_FLASH_ACC_CFG, SCB_RST_FLASH_ACC_CTRL, SCB_RST_ZERO, SCB_RST_ZERO};
      end else if (wr_flash_ctrl) begin
         flash_ctrl_ff <= reg_wdata_in;
      end else if (wr_acc_ctrl) begin
         flash_ctrl_ff[23:16] <= reg_wdata_in[7:0];
      end else if (wr_acc_cfg) begin
         flash_ctrl_ff[31:24] <= reg_wdata_in[7:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_ff <= 2'h0;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= reg_wdata_in[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------
   logic [16:0] tick_cnt_ff;
   logic [7:0] wdog_cnt_ff;
   logic wdog_tick;
   logic wdog_wrap;
   logic wdog_flag_ff;

   assign wdog_tick = (tick_cnt_ff == 17'(WDOG_TICK - 1));
   assign wdog_wrap = wdog_tick && !wr_wdog_cnt && (wdog_cnt_ff == 8'hFF);

   // Prescaler for the counter rate
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_ff <= 17'h00000;
      end else if (wdog_tick) begin
         tick_cnt_ff <= 17'h00000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 17'h00001;
      end
   end

   // Counter with software preset
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt_ff <= SCB_RST_ZERO;
      end else if (wr_wdog_cnt) begin
         wdog_cnt_ff <= reg_wdata_in[7:0];
      end else if (wdog_tick) begin
         wdog_cnt_ff <= wdog_cnt_ff + 8'h01;
      end
   end

   // Overflow flag; a wrap wins over clear
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wdog_flag_ff <= 1'b0;
      end else if (wdog_wrap) begin
         wdog_flag_ff <= 1'b1;
      end else if ((wr_wdog_ctrl && reg_wdata_in[SCB_WDOG_FLAG_BIT]) || wr_wdog_cnt) begin
         wdog_flag_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   logic [1:0] irq_status_ff;
   logic [1:0] irq_event;

   assign irq_event = {wdog_wrap, window_opened};

   // Sticky events, set wins over read clear
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_ff <= 2'h0;
      end else if (rd_irq_status) begin
         irq_status_ff <= irq_event;
      end else begin
         irq_status_ff <= irq_status_ff | irq_event;
      end
   end

   assign irq_out = |(irq_status_ff & irq_mask_ff);

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] nxt_rdata;
   logic [31:0] rdata_ff;
   logic [7:0] sig_view;

   // Unlock register read view, reserved bits zero
   assign sig_view = {1'b0, window_cnt_ff[2:0], unlock_open, 1'b0,
                      unlock_open ? SCB_STATE_CODE_SAFE : SCB_STATE_CODE_LOCKED};

   // Read mux, protected registers readable at all times
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (reg_addr_in)
         SCB_ADDR_UNLOCK_SIG: nxt_rdata = {24'h000000, sig_view};
         SCB_ADDR_PART_ID: nxt_rdata = {24'h000000, PART_ID};
         SCB_ADDR_UNLOCK_ID: nxt_rdata = {24'h000000, SCB_UNLOCK_ID_VAL};
         SCB_ADDR_WDOG_CNT: nxt_rdata = {24'h000000, wdog_cnt_ff};
         SCB_ADDR_RESET_CAUSE: nxt_rdata = {24'h000000, cause_cfg_ff};
         SCB_ADDR_CFG_INFO: nxt_rdata = {24'h000000, SCB_CFG_INFO_VAL};
         SCB_ADDR_WDOG_CTRL: nxt_rdata = {24'h000000, 3'h0, wdog_flag_ff, 1'b0, wdog_ctrl_ff[2:1], 1'b0};
         SCB_ADDR_RESET_KEEP: nxt_rdata = {24'h000000, keep_ff};
         SCB_ADDR_FLASH_WORD: nxt_rdata = flash_word_ff;
         SCB_ADDR_FLASH_CTRL_WORD: nxt_rdata = flash_ctrl_ff;
         SCB_ADDR_FLASH_ACC_CTRL: nxt_rdata = {24'h000000, flash_ctrl_ff[23:16]};
         SCB_ADDR_FLASH_ACC_CFG: nxt_rdata = {24'h000000, flash_ctrl_ff[31:24]};
         SCB_ADDR_IRQ_STATUS: nxt_rdata = {30'h00000000, irq_status_ff};
         SCB_ADDR_IRQ_MASK: nxt_rdata = {30'h00000000, irq_mask_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Registered read data, valid one cycle after strobe
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end
   assign reg_rdata_out = rdata_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_key_pair;
      (wr_sig && reg_wdata_in[7:0] == SCB_KEY_FIRST) ##1 (wr_sig && reg_wdata_in[7:0] == SCB_KEY_SECOND);
   endsequence

   AST_OPEN_AFTER_PAIR: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (unlock_state_ff == SCB_LOCKED) ##0 s_key_pair |=> unlock_open)
      else $error("window did not open after key pair");

   AST_OPEN_ONLY_VIA_KEY: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      $rose(unlock_open) |-> $past(wr_sig) && $past(reg_wdata_in[7:0]) == SCB_KEY_SECOND)
      else $error("window opened without second key");

   AST_LOCKED_NO_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      ((wr_wdog_ctrl || wr_cause) && !unlock_open) |=> $stable(wdog_ctrl_ff) && $stable(cause_cfg_ff))
      else $error("protected register written while locked");

   AST_WINDOW_LIMIT: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      $rose(unlock_open) |-> ##[1:16] !unlock_open)
      else $error("window stayed open too long");

   AST_ABORT_CLOSES: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (unlock_open && wr_sig) |=> !unlock_open)
      else $error("unlock write did not close window");

   AST_CODE_MATCHES: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      reg_rd_in && reg_addr_in == SCB_ADDR_UNLOCK_SIG |=> reg_rdata_out[3] == (reg_rdata_out[1:0] == 2'h3))
      else $error("state code and writable bit disagree");

   AST_ID_FIXED: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      reg_rd_in && reg_addr_in == SCB_ADDR_UNLOCK_ID |=> reg_rdata_out == 32'h0000_000C)
      else $error("unlock identifier wrong");

   AST_WRAP_FLAG: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      wdog_wrap |=> wdog_flag_ff && wdog_cnt_ff == 8'h00)
      else $error("wrap did not set flag");

   AST_SECOND_MISSED: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (unlock_state_ff == SCB_ARMED && reg_wr_in && !window_opened) |=> unlock_state_ff == SCB_LOCKED)
      else $error("broken key pair left sequencer armed");
endmodule : scb_bank

// ---- tb/scb_core_model.sv ----
// Processor core model issuing register port accesses
`timescale 1ns/1ps
module scb_core_model
   import scb_pkg::*;
(
   // Clock
   input wire logic core_clk_in,
   // Register port
   output logic [31:0] reg_addr_out,
   output logic [31:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [31:0] reg_rdata_in
);
   // Quiet bus at time zero
   initial begin
      reg_addr_out = 32'h0000_0000;
      reg_wdata_out = 32'h0000_0000;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   // End of a transfer: drop strobes, scramble released lines
   task automatic idle();
      @(posedge core_clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~reg_addr_out;
      reg_wdata_out <= ~reg_wdata_out;
   endtask : idle
   // One-cycle write of a byte register
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= {24'h00_0000, d};
      reg_wr_out <= 1'b1;
      idle();
   endtask : wr
   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      idle();
      #1;
      d = reg_rdata_in;
   endtask : rd
   // Ordered key pair opens the write window
   task automatic unlock();
      wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_FIRST);
      wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_SECOND);
   endtask : unlock
   // Key pair with no idle cycle between the two writes
   task automatic unlock_b2b();
      @(posedge core_clk_in);
      reg_addr_out <= SCB_ADDR_UNLOCK_SIG;
      reg_wdata_out <= {24'h00_0000, SCB_KEY_FIRST};
      reg_wr_out <= 1'b1;
      @(posedge core_clk_in);
      reg_wdata_out <= {24'h00_0000, SCB_KEY_SECOND};
      idle();
   endtask : unlock_b2b
endmodule : scb_core_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the safe access register bank
`timescale 1ns/1ps
module tb_top;
   import scb_pkg::*;
   localparam logic [7:0] PART_ID_TB = 8'h3C;  // Arbitrary value
   localparam int TICK_TB = 8;
   logic core_clk_in;
   logic reset_n_in;
   logic [31:0] addr, wdata, rdata;
   logic wr, rd, writable, irq;
   int error_cnt, tests_run, i;
   logic [31:0] d, d2;
   logic [31:0] row_addr [15];
   logic [31:0] row_exp [15];
   time t0;

   // Design and core model
   scb_bank #(.PART_ID(PART_ID_TB), .WDOG_TICK(TICK_TB)) scb_bank_inst (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .unlock_writable_out(writable), .irq_out(irq));
   scb_core_model scb_core_model_inst (.core_clk_in(core_clk_in), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));

   // 40 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end

   // Closing report
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   // Give up on a hung wait
   task automatic bail(input string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
      results();
   endtask : bail
   // Register value compare
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
      end
   endtask : chk_data
   // Status pin compare
   task automatic chk_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
      end
   endtask : chk_flag
   // Settle just past the next edge
   task automatic step();
      @(posedge core_clk_in);
      #1;
   endtask : step

   // Hang guard
   initial begin
      #(20000 * 25);
      bail("run timeout");
   end

   // Main sequence
   initial begin
      row_addr = '{SCB_ADDR_WDOG_CNT, SCB_ADDR_UNLOCK_SIG, SCB_ADDR_PART_ID, SCB_ADDR_UNLOCK_ID,
         SCB_ADDR_RESET_CAUSE, SCB_ADDR_CFG_INFO, SCB_ADDR_WDOG_CTRL, SCB_ADDR_RESET_KEEP,
         SCB_ADDR_FLASH_WORD, SCB_ADDR_FLASH_CTRL_WORD, SCB_ADDR_FLASH_ACC_CTRL, SCB_ADDR_FLASH_ACC_CFG,
         SCB_ADDR_IRQ_STATUS, SCB_ADDR_IRQ_MASK, 32'h4000_1050};
      row_exp = '{32'h00, 32'h00, {24'h0, PART_ID_TB}, 32'h0C, 32'h01, 32'hC8, 32'h00, 32'h00,
         32'h00, 32'h0740_0000, 32'h40, 32'h07, 32'h00, 32'h00, 32'h00};
      error_cnt = 0;
      tests_run = 0;
      reset_n_in = 1'b0;
      repeat (3) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      // Reset values across the map
      for (i = 0; i < 15; i++) begin
         scb_core_model_inst.rd(row_addr[i], d);
         chk_data(d, row_exp[i]);
      end
      chk_flag(writable, 1'b0);
      chk_flag(irq, 1'b0);
      // Locked writes and read-only places
      scb_core_model_inst.wr(SCB_ADDR_RESET_CAUSE, 8'hF0);
      scb_core_model_inst.wr(SCB_ADDR_PART_ID, 8'hFF);
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_ID, 8'hFF);
      scb_core_model_inst.rd(SCB_ADDR_RESET_CAUSE, d);
      chk_data(d, 32'h01);
      scb_core_model_inst.rd(SCB_ADDR_PART_ID, d);
      chk_data(d, {24'h0, PART_ID_TB});
      scb_core_model_inst.rd(SCB_ADDR_UNLOCK_ID, d);
      chk_data(d, 32'h0C);
      // Open window: status fields, elapsed count, protected write
      scb_core_model_inst.unlock();
      scb_core_model_inst.rd(SCB_ADDR_UNLOCK_SIG, d);
      scb_core_model_inst.rd(SCB_ADDR_UNLOCK_SIG, d2);
      chk_data(d & 32'hFFFF_FF8F, 32'h0B);
      chk_data(32'((d2[6:4] - d[6:4]) & 3'h7), 32'h2);
      scb_core_model_inst.wr(SCB_ADDR_RESET_CAUSE, 8'hF0);
      scb_core_model_inst.rd(SCB_ADDR_RESET_CAUSE, d);
      chk_data(d, 32'hF1);
      for (i = 0; i < 40 && writable === 1'b1; i++) step();
      if (i == 40) bail("window never closed");
      scb_core_model_inst.wr(SCB_ADDR_RESET_CAUSE, 8'h00);
      scb_core_model_inst.rd(SCB_ADDR_RESET_CAUSE, d);
      chk_data(d, 32'hF1);
      // Window length in cycles
      scb_core_model_inst.unlock();
      d = 32'h0;
      for (i = 0; i < 40; i++) begin
         #1;
         if (writable === 1'b1) d++;
         else if (d != 0) break;
         @(posedge core_clk_in);
      end
      chk_data(d, 32'd16);
      scb_core_model_inst.rd(SCB_ADDR_UNLOCK_SIG, d);
      chk_data(d, 32'h00);
      // Stray value to the unlock register closes the window
      scb_core_model_inst.unlock_b2b();
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, 8'h00);
      step();
      chk_flag(writable, 1'b0);
      scb_core_model_inst.wr(SCB_ADDR_RESET_CAUSE, 8'h00);
      scb_core_model_inst.rd(SCB_ADDR_RESET_CAUSE, d);
      chk_data(d, 32'hF1);
      // Broken key pairs stay locked
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_FIRST);
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, 8'h11);
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_SECOND);
      step();
      chk_flag(writable, 1'b0);
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_FIRST);
      scb_core_model_inst.wr(SCB_ADDR_RESET_KEEP, SCB_KEY_SECOND);
      scb_core_model_inst.wr(SCB_ADDR_UNLOCK_SIG, SCB_KEY_SECOND);
      step();
      chk_flag(writable, 1'b0);
      // Watchdog preset, wrap, rate, overflow flag and interrupt
      scb_core_model_inst.wr(SCB_ADDR_IRQ_MASK, 8'h00);
      scb_core_model_inst.rd(SCB_ADDR_IRQ_STATUS, d);
      scb_core_model_inst.wr(SCB_ADDR_WDOG_CNT, 8'hFF);
      scb_core_model_inst.rd(SCB_ADDR_WDOG_CNT, d);
      chk_data(d, 32'hFF);
      for (i = 0; i < 40 && d !== 32'h00; i++) scb_core_model_inst.rd(SCB_ADDR_WDOG_CNT, d);
      if (i == 40) bail("counter never wrapped");
      t0 = $time;
      scb_core_model_inst.rd(SCB_ADDR_WDOG_CTRL, d);
      chk_data(d & 32'h10, 32'h10);
      chk_flag(irq, 1'b0);
      for (i = 0; i < 40 && d !== 32'h01; i++) scb_core_model_inst.rd(SCB_ADDR_WDOG_CNT, d);
      if (i == 40) bail("counter never advanced");
      chk_data(32'(($time - t0) / 25), 32'(TICK_TB));
      scb_core_model_inst.wr(SCB_ADDR_IRQ_MASK, 8'h02);
      step();
      chk_flag(irq, 1'b1);
      scb_core_model_inst.rd(SCB_ADDR_IRQ_STATUS, d);
      chk_data(d & 32'h02, 32'h02);
      chk_flag(irq, 1'b0);
      scb_core_model_inst.wr(SCB_ADDR_WDOG_CTRL, 8'h16);
      scb_core_model_inst.rd(SCB_ADDR_WDOG_CTRL, d);
      chk_data(d & 32'h16, 32'h00);
      results();
   end
endmodule : tb_top
